// *** logic/urc_accept.sv ***
// decides whether a received frame may enter the receive buffer
`timescale 1ns/1ps
`default_nettype none
module urc_accept (
  // mode
  input wire logic sync_mode,
  input wire logic nine_sel,
  input wire logic addr_en,
  // frame
  input wire logic bit8,
  // decision
  output logic accept
);
  // address filter only in async nine-bit mode; 8-bit ignores it
  assign accept = ~(~sync_mode & nine_sel & addr_en & ~bit8);
endmodule
`default_nettype wire

// *** logic/urc_params.svh ***
// constants for the receive control block: offsets, bits, reset values
`ifndef URC_PARAMS_SVH
`define URC_PARAMS_SVH
// register byte offsets on the apb bus
`define URC_ADDR_RCS 8'h00
`define URC_ADDR_BUF 8'h04
`define URC_ADDR_ISTAT 8'h08
`define URC_ADDR_IMASK 8'h0C
`define URC_ADDR_MODE 8'h10
// receive status and control bit positions
`define URC_B_PORT_EN 7
`define URC_B_NINE 6
`define URC_B_SINGLE 5
`define URC_B_CONT 4
`define URC_B_ADDR 3
`define URC_B_FRAMING_ERROR_FLAG 2
`define URC_B_OVERRUN_ERROR_FLAG 1
`define URC_B_NINTH 0
// mode register bit
`define URC_B_SYNC 0
// interrupt status and mask bits
`define URC_IRQ_W 3
`define URC_IRQ_RX 0
`define URC_IRQ_OVR 1
`define URC_IRQ_FRM 2
// reset values
`define URC_RST_BYTE 8'h00
`define URC_RST_IRQ 3'h0
`define URC_RST_WORD 32'h0000_0000
`endif

// *** logic/urc_pkg.sv ***
// types shared by the receive control block
package urc_pkg;
  // whole state of the control block
  typedef struct packed {
    logic port_en;     // serial port enable
    logic nine_sel;    // nine-bit receive select
    logic single_en;   // single receive enable
    logic cont_en;     // continuous receive enable
    logic addr_en;     // address detect enable
    logic sync_mode;   // synchronous mode select
    logic [7:0] rx_data; // receive buffer
    logic ninth;       // received ninth bit
    logic framing_error_flag;        // framing error flag
    logic overrun_error_flag;        // overrun error flag
    logic full;        // buffer holds an unread character
    logic [2:0] irq_stat; // sticky event bits
    logic [2:0] irq_mask; // event enables
    logic [31:0] prdata;  // registered read data
  } urc_state_t;
endpackage

// *** logic/urc_receive_control.sv ***
// receive control and status with apb registers and interrupt
`timescale 1ns/1ps
`include "urc_params.svh"
`default_nettype none
module urc_receive_control (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // from the receive shift logic
  input wire logic frame_valid,
  input wire logic [7:0] frame_data,
  input wire logic frame_ninth,
  input wire logic frame_stop_error,
  // to the receive shift logic and port
  output logic receiver_enable,
  output logic nine_bit_receive_select,
  output logic serial_port_enable,
  output logic sync_mode,
  // interrupt
  output logic irq
);
  import urc_pkg::*;

  urc_state_t st_ff;   // registered state
  urc_state_t nxt_st;  // next state
  logic accept;        // frame passes the address filter
  logic hit;           // address is mapped
  logic acc;           // apb access phase
  logic wr_acc;        // write taking effect
  logic take;          // frame taken by the enabled receiver
  logic load;          // frame enters the buffer
  logic lost;          // frame dropped for overrun

  // address decode, used for writes and for the error answer
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `URC_ADDR_RCS) || (a == `URC_ADDR_BUF) ||
             (a == `URC_ADDR_ISTAT) || (a == `URC_ADDR_IMASK) ||
             (a == `URC_ADDR_MODE);
  endfunction

  // read word for an address
  function automatic logic [31:0] rd_word(input urc_state_t s,
                                          input logic [7:0] a);
    rd_word = `URC_RST_WORD;
    case (a)
      `URC_ADDR_RCS: rd_word[7:0] = {s.port_en, s.nine_sel, s.single_en,
        s.cont_en, s.addr_en, s.framing_error_flag, s.overrun_error_flag, s.ninth};
      `URC_ADDR_BUF: rd_word[7:0] = s.rx_data;
      `URC_ADDR_ISTAT: rd_word[`URC_IRQ_W-1:0] = s.irq_stat;
      `URC_ADDR_IMASK: rd_word[`URC_IRQ_W-1:0] = s.irq_mask;
      `URC_ADDR_MODE: rd_word[`URC_B_SYNC] = s.sync_mode;
      default: rd_word = `URC_RST_WORD;
    endcase
  endfunction

  // address filter
  urc_accept u_accept (
    .sync_mode(st_ff.sync_mode),
    .nine_sel(st_ff.nine_sel),
    .addr_en(st_ff.addr_en),
    .bit8(frame_ninth),
    .accept(accept)
  );

  // apb handshake: zero wait, error on unmapped address
  assign hit = mapped(paddr);
  assign acc = psel & penable;
  assign wr_acc = acc & pwrite & hit;
  assign pready = acc;
  assign pslverr = acc & ~hit;
  assign prdata = st_ff.prdata;

  // receiver enable per mode
  always_comb begin
    if (st_ff.sync_mode) begin
      receiver_enable = st_ff.port_en & (st_ff.cont_en | st_ff.single_en);
    end else begin
      receiver_enable = st_ff.port_en & st_ff.cont_en;
    end
  end

  // frame classification
  assign take = frame_valid & receiver_enable & accept;
  assign lost = take & (st_ff.full | st_ff.overrun_error_flag);
  assign load = take & ~lost;

  // next state
  always_comb begin
    nxt_st = st_ff;
    // read data latched in the setup cycle
    if (psel & ~penable & ~pwrite) begin
      nxt_st.prdata = rd_word(st_ff, paddr);
    end
    // register writes
    if (wr_acc) begin
      case (paddr)
        `URC_ADDR_RCS: begin
          nxt_st.port_en = pwdata[`URC_B_PORT_EN];
          nxt_st.nine_sel = pwdata[`URC_B_NINE];
          nxt_st.single_en = pwdata[`URC_B_SINGLE];
          nxt_st.cont_en = pwdata[`URC_B_CONT];
          nxt_st.addr_en = pwdata[`URC_B_ADDR];
          // clearing continuous receive clears overrun
          if (!pwdata[`URC_B_CONT]) begin
            nxt_st.overrun_error_flag = 1'b0;
          end
        end
        `URC_ADDR_ISTAT: begin
          nxt_st.irq_stat = st_ff.irq_stat & ~pwdata[`URC_IRQ_W-1:0];
        end
        `URC_ADDR_IMASK: begin
          nxt_st.irq_mask = pwdata[`URC_IRQ_W-1:0];
        end
        `URC_ADDR_MODE: begin
          nxt_st.sync_mode = pwdata[`URC_B_SYNC];
        end
        default: begin
        end
      endcase
    end
    // buffer read frees it for the next byte
    if (acc & ~pwrite & (paddr == `URC_ADDR_BUF)) begin
      nxt_st.full = 1'b0;
    end
    // frame entering the buffer, flags travel with it
    if (load) begin
      nxt_st.rx_data = frame_data;
      nxt_st.ninth = st_ff.nine_sel & frame_ninth;
      nxt_st.framing_error_flag = frame_stop_error;
      nxt_st.full = 1'b1;
      nxt_st.irq_stat[`URC_IRQ_RX] = 1'b1;
      if (frame_stop_error) begin
        nxt_st.irq_stat[`URC_IRQ_FRM] = 1'b1;
      end
      // single receive ends unless continuous overrides it
      if (st_ff.sync_mode & ~st_ff.cont_en) begin
        nxt_st.single_en = 1'b0;
      end
    end
    // lost character: set wins over the clear
    if (lost) begin
      nxt_st.overrun_error_flag = 1'b1;
      nxt_st.irq_stat[`URC_IRQ_OVR] = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs from state
  assign nine_bit_receive_select = st_ff.nine_sel;
  assign serial_port_enable = st_ff.port_en;
  assign sync_mode = st_ff.sync_mode;
  assign irq = |(st_ff.irq_stat & st_ff.irq_mask);

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  async_enable_a: assert property (
    !st_ff.sync_mode |-> receiver_enable == (st_ff.port_en & st_ff.cont_en))
    else $error("async receiver enable wrong");

  // async with continuous off: a frame must never fill the buffer
  async_off_a: assert property (
    !st_ff.sync_mode && !st_ff.cont_en && frame_valid && !st_ff.full
      |=> !st_ff.full)
    else $error("frame taken with receiver off");

  cont_keeps_a: assert property (
    st_ff.sync_mode && st_ff.cont_en && load && !wr_acc
      |=> st_ff.single_en == $past(st_ff.single_en) && receiver_enable)
    else $error("continuous receive stopped after frame");

  addr_skip_a: assert property (
    frame_valid && receiver_enable && !st_ff.sync_mode && st_ff.nine_sel
      && st_ff.addr_en && !frame_ninth
      |=> st_ff.rx_data == $past(st_ff.rx_data) && !$rose(st_ff.full))
    else $error("address frame filter loaded data");

  addr_off_a: assert property (
    frame_valid && receiver_enable && st_ff.nine_sel && !st_ff.addr_en
      && !st_ff.full && !st_ff.overrun_error_flag
      |=> st_ff.full && st_ff.rx_data == $past(frame_data))
    else $error("frame not accepted with detect off");

  eight_bit_a: assert property (
    frame_valid && receiver_enable && !st_ff.nine_sel
      && !st_ff.full && !st_ff.overrun_error_flag |=> st_ff.full)
    else $error("eight bit frame filtered");

  framing_error_flag_load_a: assert property (
    load |=> st_ff.framing_error_flag == $past(frame_stop_error))
    else $error("framing flag not refreshed");

  ninth_sel_a: assert property (
    load && !st_ff.nine_sel |=> !st_ff.ninth)
    else $error("ninth bit kept in eight bit mode");

  ovr_set_a: assert property (
    take && st_ff.full |=> st_ff.overrun_error_flag ##0 st_ff.irq_stat[`URC_IRQ_OVR])
    else $error("overrun not flagged");

  ovr_hold_a: assert property (
    st_ff.overrun_error_flag && !(wr_acc && paddr == `URC_ADDR_RCS
      && !pwdata[`URC_B_CONT]) |=> st_ff.overrun_error_flag)
    else $error("overrun cleared without continuous clear");
endmodule
`default_nettype wire

// *** test/urc_frame_src.sv ***
// remote transmitter model: hands finished frames to the control block
`timescale 1ns/1ps
`default_nettype none
module urc_frame_src (
  // clock
  input wire logic clock,
  // frame link
  output logic frame_valid,
  output logic [7:0] frame_data,
  output logic frame_ninth,
  output logic frame_stop_error
);
  // idle lines start at a neutral pattern
  initial begin
    frame_valid = 1'b0;
    frame_data = 8'h5A;
    frame_ninth = 1'b0;
    frame_stop_error = 1'b0;
  end
  // one-cycle pulse; then inverse values so stale data never looks valid
  task automatic send(input logic [7:0] d, input logic n, input logic e);
    @(posedge clock);
    frame_valid <= 1'b1;
    frame_data <= d;
    frame_ninth <= n;
    frame_stop_error <= e;
    @(posedge clock);
    frame_valid <= 1'b0;
    frame_data <= ~d;
    frame_ninth <= ~n;
    frame_stop_error <= ~e;
  endtask
endmodule
`default_nettype wire

// *** test/urc_receive_control_tb.sv ***
// self-checking bench for the receive control block
`timescale 1ns/1ps
`include "urc_params.svh"
`default_nettype none
module urc_receive_control_tb;
  import urc_pkg::*;
  logic clock = 1'b0, reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, seed = 32'h8C0A;
  logic pready, pslverr, fv, f9, fe, ren, nsel, spe, sm, irq;
  logic [7:0] fd, dat = 8'h00;
  // model of the register state
  logic port = 0, nine = 0, sgl = 0, cont = 0, addr = 0, sync = 0;
  logic full = 0, m9 = 0, mf = 0, ov = 0;
  int st = 0, msk = 0, n_fail = 0, checks_done = 0;
  urc_receive_control dut_u (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_valid(fv),
    .frame_data(fd), .frame_ninth(f9), .frame_stop_error(fe),
    .receiver_enable(ren), .nine_bit_receive_select(nsel),
    .serial_port_enable(spe), .sync_mode(sm), .irq(irq));
  urc_frame_src src_u (.clock(clock), .frame_valid(fv), .frame_data(fd),
    .frame_ninth(f9), .frame_stop_error(fe));
  // 25 MHz clock
  initial forever #20 clock = ~clock;
  // watchdog
  initial begin
    #400000;
    n_fail++;
    test_done();
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg(input logic [7:0] v);
    apb(1'b1, `URC_ADDR_RCS, {24'h0, v});
    {port, nine, sgl, cont, addr} = v[7:3];
    if (!cont) ov = 0;
  endtask
  // send a random frame and advance the model
  task automatic frame(input logic n, input logic f);
    seed = lfsr(seed);
    src_u.send(seed[7:0], n, f);
    if (port && (sync ? cont | sgl : cont) &&
        !(!sync && nine && addr && !n)) begin
      if (full || ov) begin
        ov = 1;
        st |= 2;
      end else begin
        full = 1;
        dat = seed[7:0];
        m9 = nine & n;
        mf = f;
        st |= f ? 5 : 1;
        if (sync && !cont) sgl = 0;
      end
    end
    @(posedge clock);
  endtask
  // status, events and interrupt against the model
  task automatic see();
    apb(1'b0, `URC_ADDR_RCS, 32'h0);
    chk(r, {24'h0, port, nine, sgl, cont, addr, mf, ov, m9});
    apb(1'b0, `URC_ADDR_ISTAT, 32'h0);
    chk(r, st);
    chk(irq, (st & msk) != 0);
  endtask
  task automatic pop();
    apb(1'b0, `URC_ADDR_BUF, 32'h0);
    chk(r, dat);
    full = 0;
  endtask
  task automatic clr();
    apb(1'b1, `URC_ADDR_ISTAT, st);
    st = 0;
  endtask
  task automatic test_done();
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    see();
    apb(1'b0, `URC_ADDR_MODE, 32'h0);
    chk(r, 0);
    apb(1'b0, 8'h14, 32'h0);
    chk(r, 0);
    chk(e, 1);
    $display("test reset done");
    apb(1'b1, `URC_ADDR_IMASK, 7);
    msk = 7;
    cfg(8'h80);
    // register outputs settle after the write edge
    @(negedge clock);
    chk(spe, 1);
    frame(0, 0);
    see();
    chk(ren, 0);
    cfg(8'h90);
    @(negedge clock);
    chk(ren, 1);
    frame(0, 0);
    see();
    pop();
    clr();
    $display("test enable done");
    cfg(8'hD0);
    @(negedge clock);
    chk(nsel, 1);
    frame(1, 1);
    see();
    pop();
    frame(0, 0);
    see();
    pop();
    clr();
    cfg(8'hD8);
    frame(0, 0);
    see();
    frame(1, 0);
    see();
    pop();
    clr();
    cfg(8'h98);
    frame(0, 0);
    see();
    pop();
    clr();
    $display("test address done");
    frame(0, 0);
    frame(1, 1);
    see();
    pop();
    frame(0, 0);
    see();
    apb(1'b1, `URC_ADDR_IMASK, 0);
    msk = 0;
    see();
    apb(1'b1, `URC_ADDR_IMASK, 7);
    msk = 7;
    cfg(8'h88);
    see();
    clr();
    $display("test overrun done");
    apb(1'b1, `URC_ADDR_MODE, 1);
    sync = 1;
    @(negedge clock);
    chk(sm, 1);
    cfg(8'hB0);
    frame(0, 0);
    see();
    pop();
    cfg(8'hA0);
    @(negedge clock);
    chk(ren, 1);
    frame(0, 0);
    see();
    chk(ren, 0);
    $display("test sync done");
    test_done();
  end
endmodule
`default_nettype wire
